//--- core/ecpm_fifo.v
/*
 synchronous fifo with valid/ready on both sides and a flush input.
 assumes one clock, synchronous active-high reset; depth is a power of two.
*/
module ecpm_fifo #(
   parameter WIDTH = 9,
   parameter DEPTH = 8,
   parameter AW = 3
)(
   input wire sys_clk, // system clock
   input wire rst, // synchronous reset
   input wire flush, // drop all content
   input wire [WIDTH-1:0] in_data, // write word
   input wire in_valid, // write request
   output wire in_ready, // room for a word
   output wire [WIDTH-1:0] out_data, // head word
   output wire out_valid, // head word present
   input wire out_ready, // head consumed
   output wire [AW:0] level // words held
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ptr;
   reg [AW:0] rd_ptr;
   wire push;
   wire pop;

   assign level = wr_ptr - rd_ptr;
   assign in_ready = (level != DEPTH[AW:0]) || (DEPTH == (1 << AW) && level[AW] == 1'b0);
   assign out_valid = (level != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always @(posedge sys_clk)
   begin
      if (push)
      begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always @(posedge sys_clk)
   begin
      if (rst || flush)
      begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
         end
         if (pop)
         begin
            rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule // ecpm_fifo

//--- core/ecpm_port.v
/*
 parallel port mode control: host registers, mode and direction handling,
 standard and ecp forward handshakes, ecp reverse handshake with expansion.
 assumes host strobes are one-cycle pulses synchronous to sys_clk and that
 peripheral inputs are synchronous too.
*/
// Behaviour
// - empty flag reads one when queue empty
// - mode 000 resets queue, open-collector controls
// - mode 001 direction tri-states data, reads pins
// - mode 010 sends queue with compatibility handshake
// - mode 011 shared forward queue, reverse fills
// - mode 100 epp only when option set
// - mode 110 queue access without port traffic
// - mode 111 capability words at queue offsets
// - only 010/011 handshake; entering starts transfer
// - leaving forward mode returns strobe, autofeed to ctl bits
// - reverse exit discards bytes, drops autofeed
// - byte transfers; commands go both directions
// - reverse ecp keeps handshaking to fill queue
// - host ack high data, low command
// - command bit 7 selects count or address
// - count n expands next byte n+1 times
// - host interface never stalls, single bytes
// - full flag reads one when no room
`include "ecpm_consts.vh"
module ecpm_port #(
   parameter DEPTH = 8,
   parameter AW = 3,
   parameter EPP_OPTION = 1'b0
)(
   input wire sys_clk, // system clock
   input wire rst, // synchronous reset
   input wire [10:0] host_addr, // host port offset
   input wire host_wr, // one-cycle write strobe
   input wire host_rd, // one-cycle read strobe
   input wire [7:0] host_wdata, // write data
   output reg [7:0] host_rdata, // read data, valid cycle after host_rd
   input wire chip_option_register_four, // epp support option
   input wire [7:0] pd_in, // level on data lines
   output reg [7:0] pd_out, // data line drive value
   output reg pd_oe, // data lines driven
   output reg data_strobe_n, // strobe / host clock
   output reg data_strobe_oe, // strobe driven
   output reg auto_line_feed_n, // autofeed / host acknowledge
   output reg auto_line_feed_oe, // autofeed driven
   output reg peripheral_initialize_n, // init / reverse request
   output reg peripheral_initialize_oe, // init driven
   output reg peripheral_select_n, // select in / 1284 active
   output reg peripheral_select_oe, // select in driven
   input wire ack_n, // peripheral ack / peripheral clock
   input wire busy, // busy / peripheral acknowledge line
   input wire paper_err, // paper error / ack reverse
   input wire select_in, // select
   input wire fault_n, // fault / peripheral request
   output reg epp_active // epp operation selected
);
   localparam HS_IDLE = 3'h0;
   localparam HS_SETUP = 3'h1;
   localparam HS_STROBE = 3'h2;
   localparam HS_WAITREL = 3'h3;
   localparam HS_RV_REQ = 3'h4;
   localparam HS_RV_TAKE = 3'h5;
   localparam HS_RV_REL = 3'h6;
   localparam [3:0] SETUP_CYC = `ECPM_SETUP_CYC;

   reg [7:0] data_reg;
   reg [5:0] ctl;
   reg [2:0] mode;
   reg err_int_dis;
   reg dma_en;
   reg svc;
   reg [2:0] hs;
   reg [3:0] tmr;
   reg [7:0] rv_byte;
   reg rv_cmd;
   reg rv_valid;
   reg q_pop_host;
   reg q_pop_link;
   reg [8:0] q_in;
   reg q_wr;

   wire [8:0] q_head;
   wire q_valid;
   wire q_room;
   wire [AW:0] q_level;
   wire [7:0] x_byte;
   wire x_valid;
   wire x_ready;
   wire rle_ready;
   wire dir = ctl[`ECPM_CTL_DIR];
   wire fwd_mode = (mode == `ECPM_MODE_FIFO) || (mode == `ECPM_MODE_ECP && !dir);
   wire rev_mode = (mode == `ECPM_MODE_ECP) && dir;
   wire q_flush = (mode == `ECPM_MODE_STD) || (mode == `ECPM_MODE_BIDIR);
   wire q_host_in = (host_wr && host_addr == `ECPM_OFS_QUEUE && mode != `ECPM_MODE_CFG)
      || (host_wr && host_addr == `ECPM_OFS_DATA && mode == `ECPM_MODE_ECP && !dir);
   wire q_push = (q_host_in && !q_flush) || (x_valid && x_ready);

   function is_mode_ok;
      input [2:0] cur;
      input [2:0] nxt;
      begin
         is_mode_ok = (cur == `ECPM_MODE_STD) || (cur == `ECPM_MODE_BIDIR)
            || (nxt == `ECPM_MODE_STD) || (nxt == `ECPM_MODE_BIDIR);
      end
   endfunction

   // expander output gets the queue only when the host is not writing it
   assign x_ready = rev_mode && !q_host_in && q_room;

   always @*
   begin
      q_wr = q_push;
      q_in = (x_valid && x_ready) ? {1'b0, x_byte} : {host_addr == `ECPM_OFS_DATA, host_wdata};
      q_pop_host = host_rd && host_addr == `ECPM_OFS_QUEUE && mode != `ECPM_MODE_CFG && q_valid;
      q_pop_link = 1'b0;
      if (hs == HS_WAITREL && !rev_mode)
      begin
         q_pop_link = (mode == `ECPM_MODE_FIFO) ? ack_n : !busy;
      end
   end

   ecpm_fifo #(.WIDTH(9), .DEPTH(DEPTH), .AW(AW)) u_queue (
      .sys_clk(sys_clk),
      .rst(rst),
      .flush(q_flush),
      .in_data(q_in),
      .in_valid(q_wr),
      .in_ready(q_room),
      .out_data(q_head),
      .out_valid(q_valid),
      .out_ready(q_pop_host || q_pop_link),
      .level(q_level)
   );

   ecpm_rle u_expand (
      .sys_clk(sys_clk),
      .rst(rst),
      .flush(!rev_mode),
      .in_byte(rv_byte),
      .in_cmd(rv_cmd),
      .in_valid(rv_valid),
      .in_ready(rle_ready),
      .out_byte(x_byte),
      .out_valid(x_valid),
      .out_ready(x_ready)
   );

   // host registers: every access completes in the strobe cycle
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         data_reg <= 8'h00;
         ctl <= `ECPM_CTL_RESET;
         mode <= `ECPM_MODE_STD;
         err_int_dis <= 1'b1;
         dma_en <= 1'b0;
         svc <= 1'b1;
         host_rdata <= 8'h00;
      end
      else
      begin
         if (host_wr)
         begin
            case (host_addr)
               `ECPM_OFS_DATA:
               begin
                  if (mode != `ECPM_MODE_ECP)
                  begin
                     data_reg <= host_wdata;
                  end
               end
               `ECPM_OFS_CTRL:
               begin
                  // direction only moves in mode 001
                  ctl[4:0] <= host_wdata[4:0];
                  if (mode == `ECPM_MODE_BIDIR)
                  begin
                     ctl[`ECPM_CTL_DIR] <= host_wdata[`ECPM_CTL_DIR];
                  end
               end
               `ECPM_OFS_EXTCTL:
               begin
                  if (is_mode_ok(mode, host_wdata[`ECPM_EXT_MODE_HI:`ECPM_EXT_MODE_LO]))
                  begin
                     mode <= host_wdata[`ECPM_EXT_MODE_HI:`ECPM_EXT_MODE_LO];
                  end
                  err_int_dis <= host_wdata[`ECPM_EXT_ERRINT];
                  dma_en <= host_wdata[`ECPM_EXT_DMAEN];
                  svc <= host_wdata[`ECPM_EXT_SVC];
               end
               default:
               begin
               end
            endcase
         end
         if (host_rd)
         begin
            case (host_addr)
               `ECPM_OFS_DATA:
                  host_rdata <= (mode == `ECPM_MODE_BIDIR && dir) ? pd_in : data_reg;
               `ECPM_OFS_STATUS:
                  host_rdata <= {!busy, ack_n, paper_err, select_in, fault_n, 3'h0};
               `ECPM_OFS_CTRL:
                  host_rdata <= {2'h0, ctl};
               `ECPM_OFS_QUEUE:
               begin
                  if (mode == `ECPM_MODE_CFG)
                     host_rdata <= `ECPM_CAPA_VALUE;
                  else
                     host_rdata <= q_head[7:0]; // empty read returns stale head
               end
               `ECPM_OFS_CAPB:
                  host_rdata <= (mode == `ECPM_MODE_CFG) ? `ECPM_CAPB_VALUE : 8'h00;
               `ECPM_OFS_EXTCTL:
                  host_rdata <= {mode, err_int_dis, dma_en, svc, !q_room, !q_valid};
               default:
                  host_rdata <= 8'h00;
            endcase
         end
      end
   end

   // link handshakes: forward compatibility/ecp, reverse ecp
   always @(posedge sys_clk)
   begin
      if (rst || !(fwd_mode || rev_mode))
      begin
         hs <= HS_IDLE;
         tmr <= 4'h0;
         rv_byte <= 8'h00;
         rv_cmd <= 1'b0;
         rv_valid <= 1'b0;
      end
      else
      begin
         if (rv_valid && rle_ready)
         begin
            rv_valid <= 1'b0;
         end
         case (hs)
            HS_IDLE:
            begin
               tmr <= 4'h0;
               if (rev_mode && !rv_valid && q_room && !x_valid)
                  hs <= HS_RV_REQ;
               else if (fwd_mode && q_valid && !busy)
                  hs <= HS_SETUP;
            end
            HS_SETUP:
            begin
               tmr <= tmr + 4'h1;
               if (tmr + 4'h1 >= SETUP_CYC)
               begin
                  tmr <= 4'h0;
                  hs <= HS_STROBE;
               end
            end
            HS_STROBE:
            begin
               tmr <= tmr + 4'h1;
               if (mode == `ECPM_MODE_FIFO ? (tmr + 4'h1 >= SETUP_CYC) : busy)
                  hs <= HS_WAITREL;
            end
            HS_WAITREL:
            begin
               if (mode == `ECPM_MODE_FIFO ? ack_n : !busy)
                  hs <= HS_IDLE;
            end
            HS_RV_REQ:
            begin
               if (!ack_n)
               begin
                  rv_byte <= pd_in;
                  rv_cmd <= !busy;
                  hs <= HS_RV_TAKE;
               end
            end
            HS_RV_TAKE:
            begin
               rv_valid <= 1'b1;
               hs <= HS_RV_REL;
            end
            HS_RV_REL:
            begin
               if (ack_n)
                  hs <= HS_IDLE;
            end
            default:
               hs <= HS_IDLE;
         endcase
      end
   end

   // pin drivers
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         pd_out <= 8'h00;
         pd_oe <= 1'b1;
         data_strobe_n <= 1'b1;
         data_strobe_oe <= 1'b0;
         auto_line_feed_n <= 1'b1;
         auto_line_feed_oe <= 1'b0;
         peripheral_initialize_n <= 1'b0;
         peripheral_initialize_oe <= 1'b1;
         peripheral_select_n <= 1'b1;
         peripheral_select_oe <= 1'b0;
         epp_active <= 1'b0;
      end
      else
      begin
         epp_active <= (mode == `ECPM_MODE_EPP) && chip_option_register_four && EPP_OPTION;
         if (mode == `ECPM_MODE_STD)
            pd_oe <= 1'b1;
         else
            pd_oe <= !dir || mode == `ECPM_MODE_FIFO;
         if (fwd_mode && hs != HS_IDLE)
         begin
            pd_out <= q_head[7:0];
            data_strobe_n <= !(hs == HS_STROBE);
            auto_line_feed_n <= (mode == `ECPM_MODE_ECP) ? !q_head[8] : 1'b1;
         end
         else if (rev_mode)
         begin
            pd_out <= data_reg;
            data_strobe_n <= 1'b1;
            auto_line_feed_n <= !(hs == HS_RV_REQ);
         end
         else
         begin
            pd_out <= (mode == `ECPM_MODE_TEST && q_valid) ? q_head[7:0] : data_reg;
            data_strobe_n <= !ctl[`ECPM_CTL_STROBE];
            auto_line_feed_n <= !ctl[`ECPM_CTL_AUTOFD];
         end
         peripheral_initialize_n <= ctl[`ECPM_CTL_INIT];
         peripheral_select_n <= !ctl[`ECPM_CTL_SELIN];
         // open collector in mode 000: drive only the low level
         if (mode == `ECPM_MODE_STD)
         begin
            data_strobe_oe <= ctl[`ECPM_CTL_STROBE];
            auto_line_feed_oe <= ctl[`ECPM_CTL_AUTOFD];
            peripheral_initialize_oe <= !ctl[`ECPM_CTL_INIT];
            peripheral_select_oe <= ctl[`ECPM_CTL_SELIN];
         end
         else
         begin
            data_strobe_oe <= 1'b1;
            auto_line_feed_oe <= 1'b1;
            peripheral_initialize_oe <= 1'b1;
            peripheral_select_oe <= 1'b1;
         end
      end
   end
endmodule // ecpm_port

//--- core/ecpm_rle.v
/*
 reverse-channel run-length expander: a count byte makes the next data byte
 repeat count+1 times into the queue.
 assumes the queue exerts back-pressure through out_ready.
*/
`include "ecpm_consts.vh"
module ecpm_rle (
   input wire sys_clk, // system clock
   input wire rst, // synchronous reset
   input wire flush, // abandon pending expansion
   input wire [7:0] in_byte, // byte from the link
   input wire in_cmd, // byte was a command
   input wire in_valid, // byte offered
   output wire in_ready, // byte taken
   output reg [7:0] out_byte, // expanded byte
   output reg out_valid, // expanded byte present
   input wire out_ready // queue took the byte
);
   reg [6:0] count;
   reg [6:0] pend;
   reg have_count;

   assign in_ready = !out_valid;

   always @(posedge sys_clk)
   begin
      if (rst || flush)
      begin
         out_valid <= 1'b0;
         out_byte <= 8'h00;
         count <= 7'h00;
         pend <= 7'h00;
         have_count <= 1'b0;
      end
      else if (out_valid)
      begin
         if (out_ready)
         begin
            if (count == 7'h00)
            begin
               out_valid <= 1'b0;
            end
            else
            begin
               count <= count - 7'h01;
            end
         end
      end
      else if (in_valid)
      begin
         if (in_cmd)
         begin
            // channel addresses in reverse are dropped; only counts matter
            if (!in_byte[`ECPM_CMD_ADDR_BIT])
            begin
               pend <= in_byte[6:0];
               have_count <= 1'b1;
            end
         end
         else
         begin
            out_byte <= in_byte;
            out_valid <= 1'b1;
            count <= have_count ? pend : 7'h00;
            have_count <= 1'b0;
         end
      end
   end
endmodule // ecpm_rle

//--- include/ecpm_consts.vh
/*
 constants for the parallel port mode control block: port offsets, mode codes,
 register fields, reset values and handshake timing.
 assumes a 40 mhz system clock and byte-wide host accesses.
*/
`ifndef ECPM_CONSTS_VH
`define ECPM_CONSTS_VH

// port offsets relative to the port base, 11-bit host address
`define ECPM_OFS_DATA 11'h000
`define ECPM_OFS_STATUS 11'h001
`define ECPM_OFS_CTRL 11'h002
`define ECPM_OFS_QUEUE 11'h400
`define ECPM_OFS_CAPB 11'h401
`define ECPM_OFS_EXTCTL 11'h402

// mode codes held in extended_port_control bits 7..5
`define ECPM_MODE_STD 3'h0
`define ECPM_MODE_BIDIR 3'h1
`define ECPM_MODE_FIFO 3'h2
`define ECPM_MODE_ECP 3'h3
`define ECPM_MODE_EPP 3'h4
`define ECPM_MODE_RSVD 3'h5
`define ECPM_MODE_TEST 3'h6
`define ECPM_MODE_CFG 3'h7

// field positions
`define ECPM_EXT_MODE_HI 7
`define ECPM_EXT_MODE_LO 5
`define ECPM_EXT_ERRINT 4
`define ECPM_EXT_DMAEN 3
`define ECPM_EXT_SVC 2
`define ECPM_EXT_FULL 1
`define ECPM_EXT_EMPTY 0
`define ECPM_CTL_STROBE 0
`define ECPM_CTL_AUTOFD 1
`define ECPM_CTL_INIT 2
`define ECPM_CTL_SELIN 3
`define ECPM_CTL_ACKEN 4
`define ECPM_CTL_DIR 5
`define ECPM_CMD_ADDR_BIT 7

// reset values and fixed read values
`define ECPM_EXT_RESET 8'h15
`define ECPM_CTL_RESET 6'h00
`define ECPM_CAPA_VALUE 8'h10
`define ECPM_CAPB_VALUE 8'h00

// handshake settle time on the data lines
`define ECPM_SETUP_NS 50
`define ECPM_CLK_MHZ 40
// 50 ns rounded up to whole 25 ns cycles, sized for the 4-bit setup timer
`define ECPM_SETUP_CYC 4'h2

`endif

//--- testbench/ecpm_periph.sv
/*
 peripheral model: takes forward bytes with their command tag, sends reverse
 bytes from tx_q when the host requests them.
 assumes the bench fills tx_q and reads rx_q by hierarchical reference.
*/
module ecpm_periph (
   input wire sys_clk, // system clock
   input wire rst, // reset
   input wire [7:0] pd_out, // host data drive
   input wire pd_oe, // host drives data
   input wire data_strobe_n, // host strobe
   input wire auto_line_feed_n, // host autofeed
   input wire [3:0] slow, // extra cycles before busy
   output wire [7:0] pd_in, // line level
   output logic ack_n, // peripheral clock
   output logic busy // busy or command flag
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [8:0] rx_q[$];
   logic [8:0] tx_q[$];
   logic [7:0] drv = 8'h00;
   logic drv_en;
   logic [3:0] dly;
   // released lines show the inverse so stale data never passes
   assign pd_in = pd_oe ? pd_out : (drv_en ? drv : ~drv);
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         busy <= 1'b0;
         ack_n <= 1'b1;
         drv_en <= 1'b0;
         dly <= 4'h0;
      end
      else if (pd_oe)
      begin
         if (!data_strobe_n && !busy)
         begin
            if (dly < slow)
               dly <= dly + 4'h1;
            else
            begin
               rx_q.push_back({~auto_line_feed_n, pd_out});
               busy <= 1'b1;
               dly <= 4'h0;
            end
         end
         else if (busy && data_strobe_n)
            busy <= 1'b0;
      end
      else if (ack_n && !auto_line_feed_n && tx_q.size() > 0)
      begin
         drv <= tx_q[0][7:0];
         busy <= ~tx_q[0][8];
         drv_en <= 1'b1;
         ack_n <= 1'b0;
      end
      else if (!ack_n && auto_line_feed_n)
      begin
         ack_n <= 1'b1;
         drv_en <= 1'b0;
         void'(tx_q.pop_front());
      end
   end
endmodule // ecpm_periph

//--- testbench/ecpm_port_properties.sv
/*
 concurrent checks on the ports of the parallel port mode control block.
 assumes the single sys_clk domain and the synchronous active-high rst.
*/
module ecpm_port_properties (
   input wire sys_clk, // system clock
   input wire rst, // synchronous reset
   input wire [10:0] host_addr, // host offset
   input wire host_rd, // read strobe
   input wire [7:0] host_rdata, // read data
   input wire chip_option_register_four, // epp option
   input wire [7:0] pd_out, // data drive value
   input wire pd_oe, // data lines driven
   input wire data_strobe_n, // strobe
   input wire auto_line_feed_n, // autofeed
   input wire peripheral_initialize_n, // init
   input wire busy, // peripheral busy
   input wire epp_active // epp selected
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   reset_lines_a: assert property ($fell(rst) |-> data_strobe_n && auto_line_feed_n && !peripheral_initialize_n)
      else $error("control lines wrong after reset");
   epp_option_a: assert property (epp_active |-> $past(chip_option_register_four))
      else $error("epp selected without option");
   rdata_hold_a: assert property (!host_rd |=> $stable(host_rdata))
      else $error("read data moved without a read");
   flags_excl_a: assert property (host_rd && host_addr == 11'h402 |=> !(host_rdata[1] && host_rdata[0]))
      else $error("queue full and empty together");
   setup_time_a: assert property ($fell(data_strobe_n) |-> pd_oe && $stable(pd_out) && $stable(auto_line_feed_n))
      else $error("strobe fell while data was changing");
   strobe_hold_a: assert property (!data_strobe_n |=> data_strobe_n || ($stable(pd_out) && $stable(auto_line_feed_n)))
      else $error("data or tag changed under strobe");
   strobe_min_a: assert property ($fell(data_strobe_n) |=> !data_strobe_n)
      else $error("strobe pulse too short");
   busy_release_a: assert property (!data_strobe_n && busy |-> ##2 data_strobe_n)
      else $error("strobe held after busy");
   strobe_gate_a: assert property ($fell(data_strobe_n) |-> !$past(busy) ##[1:20] data_strobe_n)
      else $error("strobe started while busy or never ended");
endmodule // ecpm_port_properties

bind ecpm_port ecpm_port_properties chk (.sys_clk, .rst, .host_addr, .host_rd, .host_rdata,
   .chip_option_register_four, .pd_out, .pd_oe, .data_strobe_n, .auto_line_feed_n,
   .peripheral_initialize_n, .busy, .epp_active);

//--- testbench/test_ecp_port_mode_control.sv
/*
 self-checking bench for the parallel port mode control block.
 assumes the peripheral model and the bound checker are compiled before it.
*/
module test_ecp_port_mode_control;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {logic w; logic [10:0] a; logic [7:0] d; logic [10:0] ra; logic [7:0] e;} ecpm_row_t;
   logic sys_clk = 1'b0, rst = 1'b1, host_wr = 1'b0, host_rd = 1'b0, opt = 1'b1;
   logic [10:0] host_addr = 11'h000;
   logic [7:0] host_wdata = 8'h00;
   logic [3:0] slow = 4'h0;
   wire [7:0] host_rdata, pd_in, pd_out;
   wire pd_oe, data_strobe_n, auto_line_feed_n, ack_n, busy, epp_active, sel_n, sel_oe;
   int miscompares = 0, n_compared = 0;
   ecpm_row_t rows [12];
   logic [8:0] fwd [4] = '{9'h185, 9'h011, 9'h103, 9'h022};
   always #12.5 sys_clk = ~sys_clk;
   ecpm_port #(.EPP_OPTION(1'b1)) dut (.sys_clk, .rst, .host_addr, .host_wr, .host_rd,
      .host_wdata, .host_rdata, .chip_option_register_four(opt), .pd_in, .pd_out, .pd_oe, .data_strobe_n,
      .data_strobe_oe(), .auto_line_feed_n, .auto_line_feed_oe(), .peripheral_initialize_n(),
      .peripheral_initialize_oe(), .peripheral_select_n(sel_n), .peripheral_select_oe(sel_oe), .ack_n, .busy,
      .paper_err(1'b0), .select_in(1'b1), .fault_n(1'b1), .epp_active);
   ecpm_periph per (.sys_clk, .rst, .pd_out, .pd_oe, .data_strobe_n, .auto_line_feed_n, .slow, .pd_in, .ack_n,
      .busy);
   task automatic end_sim;
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR at time %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic hw(input logic [10:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      host_addr = a;
      host_wdata = d;
      host_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      host_wr = 1'b0;
   endtask
   task automatic hr(input logic [10:0] a, output logic [7:0] q);
      @(posedge sys_clk);
      #1;
      host_addr = a;
      host_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      host_rd = 1'b0;
      q = host_rdata;
   endtask
   // polls the extended control word; a bound that runs out ends the run
   task automatic until_402(input logic [7:0] m, input logic [7:0] v);
      logic [7:0] q;
      int n;
      q = ~v;
      for (n = 0; n < 400 && (q & m) != v; n++)
         hr(11'h402, q);
      if ((q & m) != v)
      begin
         miscompares++;
         end_sim;
      end
   endtask
   initial
   begin
      logic [7:0] q;
      int k, j;
      rows = '{
         '{1'b1, 11'h002, 8'h3c, 11'h002, 8'h1c},
         '{1'b1, 11'h402, 8'h34, 11'h402, 8'h35},
         '{1'b1, 11'h002, 8'h20, 11'h002, 8'h20},
         '{1'b1, 11'h000, 8'h5a, 11'h000, 8'hff},
         '{1'b1, 11'h002, 8'h00, 11'h002, 8'h00},
         '{1'b1, 11'h402, 8'hd4, 11'h402, 8'hd5},
         '{1'b1, 11'h400, 8'h44, 11'h402, 8'hd4},
         '{1'b0, 11'h000, 8'h00, 11'h400, 8'h44},
         '{1'b1, 11'h402, 8'h74, 11'h402, 8'hd5},
         '{1'b1, 11'h402, 8'h34, 11'h402, 8'h35},
         '{1'b1, 11'h402, 8'hf4, 11'h400, 8'h10},
         '{1'b0, 11'h000, 8'h00, 11'h401, 8'h00}};
      repeat (5) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      foreach (rows[i])
      begin
         if (rows[i].w)
            hw(rows[i].a, rows[i].d);
         hr(rows[i].ra, q);
         chk8(q, rows[i].e);
      end
      // test mode: overfill, then drain in order
      hw(11'h402, 8'h34);
      hw(11'h402, 8'hd4);
      for (k = 1; k <= 9; k++)
         hw(11'h400, k[7:0]);
      hr(11'h402, q);
      chk8(q, 8'hd6);
      for (k = 1; k <= 8; k++)
      begin
         hr(11'h400, q);
         chk8(q, k[7:0]);
      end
      hr(11'h402, q);
      chk8(q, 8'hd5);
      // forward ecp, prompt then slow peripheral
      hw(11'h402, 8'h34);
      hw(11'h002, 8'h00);
      for (k = 0; k < 2; k++)
      begin
         slow = (k == 0) ? 4'h0 : 4'h5;
         per.rx_q.delete();
         hw(11'h402, 8'h74);
         hw(11'h000, 8'h85);
         hw(11'h400, 8'h11);
         hw(11'h000, 8'h03);
         hw(11'h400, 8'h22);
         until_402(8'h01, 8'h01);
         chk8(8'(per.rx_q.size()), 8'h04);
         for (j = 0; j < 4; j++)
         begin
            chk8(per.rx_q[j][7:0], fwd[j][7:0]);
            chk1(per.rx_q[j][8], fwd[j][8]);
         end
         hw(11'h402, 8'h34);
         chk1(data_strobe_n, 1'b1);
      end
      // compatibility fifo mode
      slow = 4'h0;
      per.rx_q.delete();
      hw(11'h402, 8'h54);
      hw(11'h400, 8'h9c);
      until_402(8'h01, 8'h01);
      chk8(per.rx_q[0][7:0], 8'h9c);
      hw(11'h402, 8'h34);
      // reverse ecp with expansion; the queue fills and stalls the expander
      hw(11'h002, 8'h20);
      per.tx_q = '{9'h102, 9'h0ab, 9'h055, 9'h17f, 9'h0c3};
      hw(11'h402, 8'h74);
      for (k = 0; k < 132; k++)
      begin
         until_402(8'h01, 8'h00);
         hr(11'h400, q);
         chk8(q, (k < 3) ? 8'hab : ((k == 3) ? 8'h55 : 8'hc3));
      end
      hw(11'h402, 8'h34);
      // pins are registered: the new mode shows one edge after the write lands
      @(posedge sys_clk);
      #1;
      chk1(auto_line_feed_n, 1'b1);
      hr(11'h402, q);
      chk8(q, 8'h35);
      // epp selection follows the option input
      hw(11'h402, 8'h94);
      repeat (2) @(posedge sys_clk);
      #1;
      chk1(epp_active, 1'b1);
      opt = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk1(epp_active, 1'b0);
      hw(11'h402, 8'h34);
      // second reset in mid-run
      rst = 1'b1;
      repeat (5) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      hr(11'h402, q);
      chk8(q, 8'h15);
      hr(11'h002, q);
      chk8(q, 8'h00);
      hw(11'h002, 8'h20);
      chk1(pd_oe, 1'b1);
      chk1(sel_oe, 1'b0);
      hw(11'h002, 8'h08);
      @(posedge sys_clk);
      #1;
      chk1(sel_oe, 1'b1);
      chk1(sel_n, 1'b0);
      end_sim;
   end
endmodule // test_ecp_port_mode_control
